// ===== core/out_point_pkg.sv
// Constants, register map and shared helpers for the output point logic.
package out_point_pkg;

    // Point count and bus widths.
    localparam int point_count = 8;
    localparam int adr_width = 8;
    localparam int dat_width = 32;

    // Register byte offsets.
    localparam logic [7:0] off_run_data = 8'h00;
    localparam logic [7:0] off_control = 8'h04;
    localparam logic [7:0] off_prog_cfg = 8'h08;
    localparam logic [7:0] off_fault_cfg = 8'h0c;
    localparam logic [7:0] off_diag_cfg = 8'h10;
    localparam logic [7:0] off_diag_reset = 8'h14;
    localparam logic [7:0] off_status = 8'h18;
    localparam logic [7:0] off_irq_status = 8'h1c;
    localparam logic [7:0] off_irq_mask = 8'h20;

    // Control register bit positions.
    localparam int ctl_online = 0;
    localparam int ctl_program = 1;
    localparam int ctl_fault = 2;
    localparam int ctl_comm_lost = 3;
    localparam int ctl_comm_to_fault = 4;
    localparam int ctl_width = 5;

    // Field positions shared by several registers.
    localparam int fld_low = 0;
    localparam int fld_high = 8;
    localparam int fuse_bit = 8;
    localparam int refused_bit = 9;
    localparam int out_field = 16;
    localparam int irq_width = 10;

    // Values after reset.
    localparam logic [7:0] rst_run_data = 8'h00;
    localparam logic [ctl_width-1:0] rst_control = 5'h00;
    localparam logic [15:0] rst_prog_cfg = 16'h0000;
    localparam logic [15:0] rst_fault_cfg = 16'h0000;
    localparam logic [15:0] rst_diag_cfg = 16'hffff;
    localparam logic [irq_width-1:0] rst_irq = 10'h000;

    // Bus answer states, Gray coded.
    typedef enum logic {
        bus_idle = 1'b0,
        bus_resp = 1'b1
    } bus_state_type;

    // Merges write data into an old value under the byte enables.
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_value,
        input logic [31:0] new_value,
        input logic [3:0] sel
    );
        logic [31:0] mask;
        mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        lane_merge = (old_value & ~mask) | (new_value & mask);
    endfunction : lane_merge

endpackage : out_point_pkg

// ===== core/output_point_safe_state_logic.sv
// Eight-point output control with safe states, diagnostics and bus slave.
// Function
// - Eight output points, zero to seven, each carry their own settings.
// - No-load detection is enabled per point and is on for all after reset.
// - With latching on, a load fault alarm stays set until it is reset.
// - A diagnostic-latch reset clears a point's alarm only while online.
// - A fuse reset clears the short/overload trip only while online.
// - In program mode a point drives its program value or holds its value.
// - In fault mode a point drives its fault value or holds its value.
// - Comm loss in program mode keeps program states or, by option, fault.
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
module output_point_safe_state_logic
    import out_point_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Wishbone classic slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [adr_width-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [dat_width-1:0] wb_dat_i,
    output logic [dat_width-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Load sensing from the output stage.
    input wire logic [point_count-1:0] no_load_in,
    input wire logic overload_in,
    // Outputs.
    output logic [point_count-1:0] point_out,
    output logic irq
);

    // Bus state.
    bus_state_type bus_q;
    bus_state_type bus_d;
    logic [dat_width-1:0] rdata_q;
    logic [dat_width-1:0] rdata_d;
    logic wr_now;

    // Software registers.
    logic [7:0] run_data_q;
    logic [7:0] run_data_d;
    logic [ctl_width-1:0] control_q;
    logic [ctl_width-1:0] control_d;
    logic [15:0] prog_cfg_q;
    logic [15:0] prog_cfg_d;
    logic [15:0] fault_cfg_q;
    logic [15:0] fault_cfg_d;
    logic [15:0] diag_cfg_q;
    logic [15:0] diag_cfg_d;
    logic [irq_width-1:0] irq_status_q;
    logic [irq_width-1:0] irq_status_d;
    logic [irq_width-1:0] irq_mask_q;
    logic [irq_width-1:0] irq_mask_d;
    logic [31:0] merged;

    // Pin synchronisers and filtered levels.
    logic [point_count:0] sync1_q;
    logic [point_count:0] sync2_q;
    logic [point_count:0] sync3_q;
    logic [point_count:0] level_q;
    logic [point_count:0] level_d;

    // Trip and reset commands.
    logic trip_q;
    logic trip_d;
    logic reset_cmd;
    logic online;
    logic [point_count-1:0] latch_clear;
    logic fuse_clear;
    logic refused;
    logic [fuse_bit:0] reset_req;

    // Operating condition and per-point results.
    logic prog_active;
    logic fault_active;
    logic [point_count-1:0] alarm;
    logic [point_count-1:0] alarm_rise;
    logic trip_rise;
    logic [irq_width-1:0] events;

    // Keeps only the reset request bits whose byte lane is enabled, so a
    // write that leaves a lane out clears nothing in it.
    function automatic logic [fuse_bit:0] reset_bits(
        input logic [dat_width-1:0] data,
        input logic [3:0] lanes
    );
        reset_bits = data[fuse_bit:0] & {lanes[1], {point_count{lanes[0]}}};
    endfunction : reset_bits

    // Answers one cycle after the request; a write lands on the ack edge.
    always_comb begin
        bus_d = bus_q;
        rdata_d = rdata_q;
        wr_now = 1'b0;
        unique case (bus_q)
            bus_idle: begin
                if (wb_cyc_i && wb_stb_i) begin
                    bus_d = bus_resp;
                    // The read word is captured at the request edge.
                    rdata_d = '0;
                    unique case (wb_adr_i)
                        off_run_data: rdata_d[7:0] = run_data_q;
                        off_control: rdata_d[ctl_width-1:0] = control_q;
                        off_prog_cfg: rdata_d[15:0] = prog_cfg_q;
                        off_fault_cfg: rdata_d[15:0] = fault_cfg_q;
                        off_diag_cfg: rdata_d[15:0] = diag_cfg_q;
                        off_status: begin
                            rdata_d[fld_low +: point_count] = alarm;
                            rdata_d[fuse_bit] = trip_q;
                            rdata_d[out_field +: point_count] = point_out;
                        end
                        off_irq_status: rdata_d[irq_width-1:0] = irq_status_q;
                        off_irq_mask: rdata_d[irq_width-1:0] = irq_mask_q;
                        default: rdata_d = '0;
                    endcase
                end
            end
            bus_resp: begin
                // A write lands only while its request still stands.
                bus_d = bus_idle;
                wr_now = wb_we_i && wb_cyc_i && wb_stb_i;
            end
        endcase
    end

    // Registers the bus state.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_q <= bus_idle;
            rdata_q <= '0;
        end else begin
            bus_q <= bus_d;
            rdata_q <= rdata_d;
        end
    end

    // Ack is high for the single answer cycle.
    assign wb_ack_o = (bus_q == bus_resp);
    assign wb_dat_o = rdata_q;

    // The controller must be online for either reset command; one sent
    // while offline changes nothing and only raises the refused event.
    assign online = control_q[ctl_online];
    assign reset_cmd = wr_now && (wb_adr_i == off_diag_reset);
    assign reset_req = reset_bits(wb_dat_i, wb_sel_i);
    assign latch_clear = (reset_cmd && online) ?
        reset_req[fld_low +: point_count] : '0;
    assign fuse_clear = reset_cmd && online && reset_req[fuse_bit];
    assign refused = reset_cmd && !online && (reset_req != '0);

    // Writes configuration under the byte enables; status bits clear by
    // writing one, and a new event in the same cycle wins.
    always_comb begin
        run_data_d = run_data_q;
        control_d = control_q;
        prog_cfg_d = prog_cfg_q;
        fault_cfg_d = fault_cfg_q;
        diag_cfg_d = diag_cfg_q;
        irq_mask_d = irq_mask_q;
        irq_status_d = irq_status_q | events;
        merged = '0;
        if (wr_now) begin
            unique case (wb_adr_i)
                off_run_data: begin
                    merged = lane_merge({24'h0, run_data_q}, wb_dat_i,
                        wb_sel_i);
                    run_data_d = merged[7:0];
                end
                off_control: begin
                    merged = lane_merge({27'h0, control_q}, wb_dat_i,
                        wb_sel_i);
                    control_d = merged[ctl_width-1:0];
                end
                off_prog_cfg: begin
                    merged = lane_merge({16'h0, prog_cfg_q}, wb_dat_i,
                        wb_sel_i);
                    prog_cfg_d = merged[15:0];
                end
                off_fault_cfg: begin
                    merged = lane_merge({16'h0, fault_cfg_q}, wb_dat_i,
                        wb_sel_i);
                    fault_cfg_d = merged[15:0];
                end
                off_diag_cfg: begin
                    merged = lane_merge({16'h0, diag_cfg_q}, wb_dat_i,
                        wb_sel_i);
                    diag_cfg_d = merged[15:0];
                end
                off_irq_status: begin
                    merged = lane_merge(32'h0, wb_dat_i, wb_sel_i);
                    irq_status_d = (irq_status_q & ~merged[irq_width-1:0])
                        | events;
                end
                off_irq_mask: begin
                    merged = lane_merge({22'h0, irq_mask_q}, wb_dat_i,
                        wb_sel_i);
                    irq_mask_d = merged[irq_width-1:0];
                end
                default: merged = '0;
            endcase
        end
    end

    // Registers the software state.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_data_q <= rst_run_data;
            control_q <= rst_control;
            prog_cfg_q <= rst_prog_cfg;
            fault_cfg_q <= rst_fault_cfg;
            diag_cfg_q <= rst_diag_cfg;
            irq_status_q <= rst_irq;
            irq_mask_q <= rst_irq;
        end else begin
            run_data_q <= run_data_d;
            control_q <= control_d;
            prog_cfg_q <= prog_cfg_d;
            fault_cfg_q <= fault_cfg_d;
            diag_cfg_q <= diag_cfg_d;
            irq_status_q <= irq_status_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // A sensed level changes only once the second and third stages agree.
    always_comb begin
        level_d = (sync2_q & sync3_q) | (level_q & (sync2_q ^ sync3_q));
    end

    // Three-stage synchronisers for the sensing pins.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            level_q <= '0;
        end else begin
            sync1_q <= {overload_in, no_load_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            level_q <= level_d;
        end
    end

    // The trip stays until a fuse reset; an overload still present wins.
    always_comb begin
        trip_d = level_q[point_count] | (trip_q & ~fuse_clear);
        trip_rise = level_q[point_count] & ~trip_q;
    end

    // Registers the trip.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trip_q <= 1'b0;
        end else begin
            trip_q <= trip_d;
        end
    end

    // Fault mode overrides program mode; lost communication in program
    // mode moves to fault states only when the option is set.
    assign fault_active = control_q[ctl_fault] ||
        (control_q[ctl_program] && control_q[ctl_comm_lost] &&
        control_q[ctl_comm_to_fault]);
    assign prog_active = control_q[ctl_program];

    // One slice per point, each with its own settings.
    for (genvar i = 0; i < point_count; i++) begin : g_point
        point_slice u_slice (
            .clk(clk),
            .rstn(rstn),
            .prog_active(prog_active),
            .fault_active(fault_active),
            .trip(trip_q),
            .run_value(run_data_q[i]),
            .prog_select(prog_cfg_q[fld_low + i]),
            .prog_value(prog_cfg_q[fld_high + i]),
            .fault_select(fault_cfg_q[fld_low + i]),
            .fault_value(fault_cfg_q[fld_high + i]),
            .no_load_enable(diag_cfg_q[fld_low + i]),
            .latch_enable(diag_cfg_q[fld_high + i]),
            .no_load_seen(level_q[i]),
            .latch_clear(latch_clear[i]),
            .drive_q(point_out[i]),
            .alarm_q(alarm[i]),
            .alarm_rise(alarm_rise[i])
        );
    end

    // Interrupt events share the status layout: alarm rises in the low
    // byte, then the trip rise, then the refused reset command.
    always_comb begin
        events = '0;
        events[fld_low +: point_count] = alarm_rise;
        events[fuse_bit] = trip_rise;
        events[refused_bit] = refused;
    end

    // The level output is high while any unmasked status bit is set.
    assign irq = |(irq_status_q & irq_mask_q);

endmodule : output_point_safe_state_logic

// ===== core/point_slice.sv
// One output point: safe-state selection and latched no-load alarm.
`timescale 1ns/10ps
module point_slice
    import out_point_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Operating condition.
    input wire logic prog_active,
    input wire logic fault_active,
    input wire logic trip,
    input wire logic run_value,
    // Safe-state settings.
    input wire logic prog_select,
    input wire logic prog_value,
    input wire logic fault_select,
    input wire logic fault_value,
    // Diagnostics.
    input wire logic no_load_enable,
    input wire logic latch_enable,
    input wire logic no_load_seen,
    input wire logic latch_clear,
    output logic drive_q,
    output logic alarm_q,
    output logic alarm_rise
);

    logic drive_d;
    logic alarm_d;
    logic detect;

    // Picks the output value; select high keeps the value already driven.
    always_comb begin
        drive_d = run_value;
        if (trip) begin
            drive_d = 1'b0;
        end else if (fault_active) begin
            drive_d = fault_select ? drive_q : fault_value;
        end else if (prog_active) begin
            drive_d = prog_select ? drive_q : prog_value;
        end
    end

    // A detected fault holds while latching is on; a new detection beats
    // the clear in the same cycle.
    always_comb begin
        detect = no_load_enable & no_load_seen;
        if (latch_enable) begin
            alarm_d = detect | (alarm_q & ~latch_clear);
        end else begin
            alarm_d = detect;
        end
        alarm_rise = detect & ~alarm_q;
    end

    // Registers the point state.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drive_q <= 1'b0;
            alarm_q <= 1'b0;
        end else begin
            drive_q <= drive_d;
            alarm_q <= alarm_d;
        end
    end

endmodule : point_slice

// ===== verif/load_stage_model.sv
// Output stage model: reports open lines and shorts on the sense pins.
`timescale 1ns/10ps
module load_stage_model #(
    parameter int settle = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Faults placed on the field wiring.
    input wire logic [7:0] open_req,
    input wire logic short_req,
    // Sense pins toward the block.
    output logic [7:0] no_load_in,
    output logic overload_in
);
    logic [8:0] pipe_q [0:7];
    // Delays each fault by settle cycles, as a slow sense circuit would.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) begin
                pipe_q[i] <= 9'h000;
            end
        end else begin
            pipe_q[0] <= {short_req, open_req};
            for (int i = 1; i < 8; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end
    assign {overload_in, no_load_in} = pipe_q[settle-1];
endmodule : load_stage_model

// ===== verif/output_point_safe_state_logic_asserts.sv
// Concurrent checks on the output point block ports.
`timescale 1ns/10ps
module output_point_safe_state_logic_asserts
    import out_point_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Bus.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [adr_width-1:0] wb_adr_i,
    input wire logic [dat_width-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins.
    input wire logic [point_count-1:0] no_load_in,
    input wire logic overload_in,
    input wire logic [point_count-1:0] point_out,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [3:0] quiet_q;
    // Counts cycles since the last write or sense pin change.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            quiet_q <= 4'h0;
        end else if ((wb_ack_o && wb_we_i) || $changed(no_load_in)
                || $changed(overload_in)) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hf) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    // Bus and pin steps.
    sequence s_request;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_read_ack;
        wb_ack_o && !wb_we_i;
    endsequence
    sequence s_overload_held;
        overload_in [*7];
    endsequence
    a_ack_answer: assert property (s_request |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i))
        else $error("ack without request");
    a_unmapped_zero: assert property (s_read_ack ##0 wb_adr_i >= 8'h24
        |-> wb_dat_o == '0) else $error("unmapped read not zero");
    a_reset_reads: assert property (
        s_read_ack ##0 wb_adr_i == off_diag_reset |-> wb_dat_o == '0)
        else $error("reset register read not zero");
    a_status_out: assert property (
        s_read_ack ##0 wb_adr_i == off_status |->
        wb_dat_o[23:16] == $past(point_out) || wb_dat_o[23:16] == point_out)
        else $error("status outputs differ from pins");
    a_trip_off: assert property (s_overload_held |=> point_out == '0)
        else $error("outputs on during overload");
    a_out_quiet: assert property (quiet_q > 4'h8 |-> $stable(point_out))
        else $error("outputs moved without cause");
    a_irq_quiet: assert property (quiet_q > 4'h8 |-> $stable(irq))
        else $error("interrupt moved without cause");
endmodule : output_point_safe_state_logic_asserts

// ===== verif/test_output_point_safe_state_logic.sv
// Self-checking bench for the output point safe-state block.
`timescale 1ns/10ps
module test_output_point_safe_state_logic
    import out_point_pkg::*;
    ;
    logic clk, rstn, cyc, stb, we, ack, irq, overload, short_req;
    logic [adr_width-1:0] adr;
    logic [3:0] sel;
    logic [dat_width-1:0] wdat, rdat, q;
    logic [point_count-1:0] no_load, pout, open_req;
    int miscompares, n_compared;

    // Clock of 100 MHz.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    output_point_safe_state_logic i_output_point_safe_state_logic (
        .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .no_load_in(no_load),
        .overload_in(overload), .point_out(pout), .irq(irq));
    load_stage_model #(.settle(3)) i_load_stage_model (
        .clk(clk), .rstn(rstn), .open_req(open_req),
        .short_req(short_req), .no_load_in(no_load),
        .overload_in(overload));

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // Compares one value.
    task automatic check(input string name, input logic [31:0] e,
            input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask : check

    // One classic Wishbone cycle; read data lands in q.
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            miscompares++;
            results();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    // Reads a register and compares the bits under a mask.
    task automatic rdc(input string name, input logic [7:0] a,
            input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check(name, e, q & m);
    endtask : rdc

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Waits a bounded time for the outputs to reach a value.
    task automatic wait_out(input logic [7:0] e);
        int n;
        n = 0;
        while (pout !== e && n < 20) begin
            @(posedge clk);
            n++;
        end
        check("point_out", 32'(e), 32'(pout));
        if (pout !== e) begin
            results();
        end
    endtask : wait_out

    // Main sequence.
    initial begin
        rstn = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hf;
        wdat = 32'h0;
        open_req = 8'h00;
        short_req = 1'b0;
        miscompares = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rdc("control", off_control, 32'h1f, 32'h0);
        rdc("prog_cfg", off_prog_cfg, 32'hffff, 32'h0);
        rdc("fault_cfg", off_fault_cfg, 32'hffff, 32'h0);
        rdc("diag_cfg", off_diag_cfg, 32'hffff, 32'hffff);
        rdc("unmapped", 8'h40, 32'hffffffff, 32'h0);
        rdc("diag_reset", off_diag_reset, 32'hffffffff, 32'h0);
        $display("reset test done");
        wr(off_run_data, 32'ha5);
        wait_out(8'ha5);
        wr(off_prog_cfg, 32'h3c0f);
        wr(off_control, 32'h3);
        wait_out(8'h35);
        wr(off_run_data, 32'h0);
        tick(12);
        check("point_out", 32'h35, 32'(pout));
        wr(off_fault_cfg, 32'h81f0);
        wr(off_control, 32'h5);
        wait_out(8'h31);
        wr(off_prog_cfg, 32'h3c00);
        wr(off_control, 32'h3);
        wait_out(8'h3c);
        wr(off_control, 32'hb);
        tick(12);
        check("point_out", 32'h3c, 32'(pout));
        wr(off_control, 32'h1b);
        wait_out(8'h31);
        $display("safe state test done");
        wr(off_control, 32'h1);
        open_req <= 8'h04;
        tick(12);
        rdc("alarms", off_status, 32'hff, 32'h04);
        rdc("irq_status", off_irq_status, 32'h3ff, 32'h004);
        check("irq", 32'h0, 32'(irq));
        wr(off_irq_mask, 32'h3ff);
        tick(3);
        check("irq", 32'h1, 32'(irq));
        open_req <= 8'h00;
        tick(12);
        rdc("alarms", off_status, 32'hff, 32'h04);
        wr(off_control, 32'h0);
        wr(off_diag_reset, 32'h4);
        rdc("alarms", off_status, 32'hff, 32'h04);
        rdc("irq_status", off_irq_status, 32'h3ff, 32'h204);
        wr(off_control, 32'h1);
        wr(off_diag_reset, 32'h4);
        rdc("alarms", off_status, 32'hff, 32'h00);
        wr(off_irq_status, 32'h3ff);
        rdc("irq_status", off_irq_status, 32'h3ff, 32'h0);
        tick(3);
        check("irq", 32'h0, 32'(irq));
        wr(off_diag_cfg, 32'hdffb);
        open_req <= 8'h24;
        tick(12);
        rdc("alarms", off_status, 32'hff, 32'h20);
        open_req <= 8'h00;
        tick(12);
        rdc("alarms", off_status, 32'hff, 32'h00);
        $display("diagnostic test done");
        wr(off_run_data, 32'hff);
        wait_out(8'hff);
        short_req <= 1'b1;
        tick(14);
        rdc("status", off_status, 32'hff0100, 32'h100);
        short_req <= 1'b0;
        wr(off_control, 32'h0);
        wr(off_diag_reset, 32'h100);
        tick(12);
        check("point_out", 32'h0, 32'(pout));
        rdc("irq_status", off_irq_status, 32'h3ff, 32'h320);
        wr(off_control, 32'h1);
        sel <= 4'h1;
        wr(off_diag_reset, 32'h100);
        sel <= 4'hf;
        tick(12);
        check("point_out", 32'h0, 32'(pout));
        wr(off_diag_reset, 32'h100);
        wait_out(8'hff);
        $display("fuse test done");
        results();
    end
endmodule : test_output_point_safe_state_logic

bind output_point_safe_state_logic output_point_safe_state_logic_asserts
    i_output_point_safe_state_logic_asserts (
    .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .no_load_in(no_load_in),
    .overload_in(overload_in), .point_out(point_out), .irq(irq));
